// *** design/tcc_core.v ***
// Purpose: three 16-bit timer channels with capture, triggers and clock chaining
// Assumes: external pins are asynchronous and slower than sys_clk / 2.5
// Notes: waveform output controller is reduced to toggles: line a on period match, line b on counter wrap
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "tcc_regs.vh"

module tcc_core #(
  parameter CNT_W = 16
) (
  // clock and reset
  input wire sys_clk,
  input wire srst,
  // register port
  input wire [`TCC_ADDR_W-1:0] reg_addr,
  input wire [`TCC_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`TCC_DATA_W-1:0] reg_rdata,
  // external clock pins
  input wire [2:0] ext_clock_pin,
  // io line a per channel
  input wire [2:0] chan_io_line_a_in,
  output reg [2:0] chan_io_line_a_out,
  output reg [2:0] chan_io_line_a_oe,
  // io line b per channel
  input wire [2:0] chan_io_line_b_in,
  output reg [2:0] chan_io_line_b_out,
  output reg [2:0] chan_io_line_b_oe
);

  localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam PAD_W = `TCC_DATA_W - CNT_W;

  function edge_hit;
    input [1:0] mode;
    input prev;
    input cur;
    begin
      case (mode)
        `TCC_EDGE_RISE: edge_hit = cur & ~prev;
        `TCC_EDGE_FALL: edge_hit = ~cur & prev;
        `TCC_EDGE_BOTH: edge_hit = cur ^ prev;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  // one command bit of a channel control write
  function ccr_hit;
    input wr;
    input [5:0] o;
    input [`TCC_DATA_W-1:0] d;
    input integer b;
    begin
      ccr_hit = wr & (o == `TCC_OFF_CCR) & d[b];
    end
  endfunction

  // ==========================================
  // state
  reg [8:0] pin_s1;
  reg [8:0] pin_s2;
  reg [`TCC_PRE_W-1:0] pre;
  reg [`TCC_BMR_W-1:0] bmr;
  reg [`TCC_CMR_W-1:0] cmr [0:2];
  reg [CNT_W-1:0] cnt [0:2];
  reg [CNT_W-1:0] cap_a [0:2];
  reg [CNT_W-1:0] cap_b [0:2];
  reg [CNT_W-1:0] per [0:2];
  reg [2:0] clk_en;
  reg [2:0] clk_run;
  reg [2:0] trg_pend;
  reg [2:0] a_done;
  reg [2:0] a_unread;
  reg [2:0] b_unread;
  reg [2:0] ovf;
  reg [2:0] ovr;
  reg [2:0] clk_prev;
  reg [2:0] a_prev;
  reg [2:0] b_prev;
  reg [2:0] xc_prev;

  // ==========================================
  // combinational views
  wire [2:0] pin_clk = pin_s2[2:0];
  wire [2:0] pin_a = pin_s2[5:3];
  wire [2:0] pin_b = pin_s2[8:6];
  // line level as seen inside: own drive while its output enable is set, pin otherwise
  wire [2:0] line_a = (chan_io_line_a_oe & chan_io_line_a_out) | (~chan_io_line_a_oe & pin_a);
  wire [2:0] line_b = (chan_io_line_b_oe & chan_io_line_b_out) | (~chan_io_line_b_oe & pin_b);
  wire is_block = (reg_addr[7:6] == `TCC_BLOCK_SEL);
  wire [5:0] off = reg_addr[5:0];
  wire sync_w = reg_wr & (reg_addr == `TCC_ADDR_BCR) & reg_wdata[`TCC_BCR_SYNC];

  reg [2:0] xc;
  reg [2:0] clk_lvl;
  reg [2:0] gate_ok;
  reg [2:0] edge_act;
  reg [2:0] ext_trg;
  reg [2:0] ld_a;
  reg [2:0] ld_b;
  reg [2:0] step;
  reg [2:0] take_trg;
  reg [2:0] pmatch;
  reg [2:0] wave;
  reg [2:0] ch_wr;
  reg [2:0] ch_rd;
  reg [2:0] en_cmd;
  reg [2:0] dis_cmd;
  reg [2:0] sw_cmd;
  reg [2:0] trg_req;
  reg [2:0] stop_ev;
  reg [2:0] dis_ev;
  reg ev_src;
  reg ev_prev;
  integer k;

  always @* begin
    for (k = 0; k < 3; k = k + 1) begin
      case (bmr[2*k +: 2])
        `TCC_XC_PIN: xc[k] = pin_clk[k];
        `TCC_XC_NEXT: xc[k] = line_a[(k+1)%3];
        `TCC_XC_PREV: xc[k] = line_a[(k+2)%3];
        default: xc[k] = 1'b0;
      endcase
    end
    for (k = 0; k < 3; k = k + 1) begin
      wave[k] = cmr[k][`TCC_CMR_WAVE];
      ch_wr[k] = reg_wr & ~is_block & (reg_addr[7:6] == k[1:0]);
      ch_rd[k] = reg_rd & ~is_block & (reg_addr[7:6] == k[1:0]);
      case (cmr[k][`TCC_CMR_CLKSEL])
        `TCC_CLK_DIV2: clk_lvl[k] = pre[`TCC_BIT_DIV2];
        `TCC_CLK_DIV8: clk_lvl[k] = pre[`TCC_BIT_DIV8];
        `TCC_CLK_DIV32: clk_lvl[k] = pre[`TCC_BIT_DIV32];
        `TCC_CLK_DIV128: clk_lvl[k] = pre[`TCC_BIT_DIV128];
        `TCC_CLK_DIV1024: clk_lvl[k] = pre[`TCC_BIT_DIV1024];
        `TCC_CLK_XC0: clk_lvl[k] = xc[0];
        `TCC_CLK_XC1: clk_lvl[k] = xc[1];
        default: clk_lvl[k] = xc[2];
      endcase
      clk_lvl[k] = clk_lvl[k] ^ cmr[k][`TCC_CMR_CLKINV];
      if (cmr[k][`TCC_CMR_GATE] == `TCC_GATE_NONE)
        gate_ok[k] = 1'b1;
      else
        gate_ok[k] = xc[cmr[k][`TCC_CMR_GATE] - 2'h1];
      edge_act[k] = clk_lvl[k] & ~clk_prev[k] & gate_ok[k] & clk_en[k];
      // external trigger source
      if (!wave[k]) begin
        ev_src = cmr[k][`TCC_CMR_CAPSRC_A] ? line_a[k] : line_b[k];
        ev_prev = cmr[k][`TCC_CMR_CAPSRC_A] ? a_prev[k] : b_prev[k];
      end else if (cmr[k][`TCC_CMR_EVSRC] == `TCC_EV_LINE_B) begin
        ev_src = line_b[k];
        ev_prev = b_prev[k];
      end else begin
        ev_src = xc[cmr[k][`TCC_CMR_EVSRC] - 2'h1];
        ev_prev = xc_prev[cmr[k][`TCC_CMR_EVSRC] - 2'h1];
      end
      ext_trg[k] = edge_hit(cmr[k][`TCC_CMR_TRGEDGE], ev_prev, ev_src)
                   & (~wave[k] | cmr[k][`TCC_CMR_EVTRG_EN]);
      // capture order: first only when not done, second only after first
      ld_a[k] = ~wave[k] & ~a_done[k]
                & edge_hit(cmr[k][`TCC_CMR_LDA], a_prev[k], line_a[k]);
      ld_b[k] = ~wave[k] & a_done[k]
                & edge_hit(cmr[k][`TCC_CMR_LDB], a_prev[k], line_a[k]);
      take_trg[k] = edge_act[k] & trg_pend[k];
      step[k] = edge_act[k] & ~trg_pend[k] & clk_run[k];
      pmatch[k] = step[k] & ((cnt[k] + CNT_ONE) == per[k]);
      en_cmd[k] = ccr_hit(ch_wr[k], off, reg_wdata, `TCC_CCR_EN);
      dis_cmd[k] = ccr_hit(ch_wr[k], off, reg_wdata, `TCC_CCR_DIS);
      sw_cmd[k] = ccr_hit(ch_wr[k], off, reg_wdata, `TCC_CCR_SOFT_TRIGGER_CMD);
      // enable and trigger in one write must not lose the trigger
      trg_req[k] = (clk_en[k] | en_cmd[k]) & ~dis_cmd[k]
                   & (sw_cmd[k] | sync_w | ext_trg[k]
                      | (pmatch[k] & cmr[k][`TCC_CMR_CTRG]));
      // stop and disable events share one source
      stop_ev[k] = (ld_b[k] | (pmatch[k] & wave[k])) & cmr[k][`TCC_CMR_STOP];
      dis_ev[k] = (ld_b[k] | (pmatch[k] & wave[k])) & cmr[k][`TCC_CMR_DIS];
    end
  end

  // ==========================================
  // channel logic
  integer i;

  always @(posedge sys_clk) begin
    if (srst) begin
      pin_s1 <= 9'h000;
      pin_s2 <= 9'h000;
      pre <= `TCC_PRE_RST;
      bmr <= `TCC_BMR_RST;
      clk_en <= 3'h0;
      clk_run <= 3'h0;
      trg_pend <= 3'h0;
      a_done <= 3'h0;
      a_unread <= 3'h0;
      b_unread <= 3'h0;
      ovf <= 3'h0;
      ovr <= 3'h0;
      clk_prev <= 3'h0;
      a_prev <= 3'h0;
      b_prev <= 3'h0;
      xc_prev <= 3'h0;
      chan_io_line_a_out <= 3'h0;
      chan_io_line_a_oe <= 3'h0;
      chan_io_line_b_out <= 3'h0;
      chan_io_line_b_oe <= 3'h0;
      for (i = 0; i < 3; i = i + 1) begin
        cmr[i] <= `TCC_CMR_RST;
        cnt[i] <= CNT_ZERO;
        cap_a[i] <= CNT_ZERO;
        cap_b[i] <= CNT_ZERO;
        per[i] <= CNT_ZERO;
      end
    end else begin
      pin_s1 <= {chan_io_line_b_in, chan_io_line_a_in, ext_clock_pin};
      pin_s2 <= pin_s1;
      pre <= pre + `TCC_PRE_ONE;
      clk_prev <= clk_lvl;
      a_prev <= line_a;
      b_prev <= line_b;
      xc_prev <= xc;
      if (reg_wr && reg_addr == `TCC_ADDR_BMR)
        bmr <= reg_wdata[`TCC_BMR_W-1:0];
      for (i = 0; i < 3; i = i + 1) begin
        // software writes
        if (ch_wr[i] && off == `TCC_OFF_CMR)
          cmr[i] <= reg_wdata[`TCC_CMR_W-1:0];
        if (ch_wr[i] && off == `TCC_OFF_RC)
          per[i] <= reg_wdata[CNT_W-1:0];
        // capture registers are read-only in capture mode
        if (ch_wr[i] && off == `TCC_OFF_RA && wave[i])
          cap_a[i] <= reg_wdata[CNT_W-1:0];
        if (ch_wr[i] && off == `TCC_OFF_RB && wave[i])
          cap_b[i] <= reg_wdata[CNT_W-1:0];

        // counter
        if (take_trg[i]) begin
          cnt[i] <= CNT_ZERO;
          clk_run[i] <= 1'b1;
          trg_pend[i] <= 1'b0;
          a_done[i] <= 1'b0;
        end else if (step[i]) begin
          cnt[i] <= cnt[i] + CNT_ONE;
        end
        // stop is skipped when a trigger is taken, so a simultaneous trigger wins
        if (clk_en[i] && stop_ev[i] && !take_trg[i])
          clk_run[i] <= 1'b0;

        // triggers are only accepted while the clock is enabled or being enabled by the same write
        if (trg_req[i])
          trg_pend[i] <= 1'b1;

        // disabling also stops, so only a trigger restarts counting
        if (dis_ev[i]) begin
          clk_en[i] <= 1'b0;
          clk_run[i] <= 1'b0;
          trg_pend[i] <= 1'b0;
        end
        if (en_cmd[i])
          clk_en[i] <= 1'b1;
        if (dis_cmd[i]) begin
          clk_en[i] <= 1'b0;
          clk_run[i] <= 1'b0;
          trg_pend[i] <= 1'b0;
        end

        // capture loads; a read clears unread, a load in the same cycle wins
        if (ch_rd[i] && off == `TCC_OFF_RA)
          a_unread[i] <= 1'b0;
        if (ch_rd[i] && off == `TCC_OFF_RB)
          b_unread[i] <= 1'b0;
        if (ld_a[i]) begin
          cap_a[i] <= cnt[i];
          a_unread[i] <= 1'b1;
          a_done[i] <= 1'b1;
        end
        if (ld_b[i]) begin
          cap_b[i] <= cnt[i];
          b_unread[i] <= 1'b1;
          a_done[i] <= 1'b0;
        end

        // event flags: status read clears, a new event wins
        if (ch_rd[i] && off == `TCC_OFF_SR) begin
          ovf[i] <= 1'b0;
          ovr[i] <= 1'b0;
        end
        if (step[i] && cnt[i] == CNT_MAX)
          ovf[i] <= 1'b1;
        if ((ld_a[i] && a_unread[i]) || (ld_b[i] && b_unread[i]))
          ovr[i] <= 1'b1;

        // line drive; full output controller not provided
        chan_io_line_a_oe[i] <= wave[i];
        chan_io_line_b_oe[i] <= wave[i]
                                & (cmr[i][`TCC_CMR_EVSRC] != `TCC_EV_LINE_B);
        if (!wave[i])
          chan_io_line_a_out[i] <= 1'b0;
        else if (pmatch[i])
          chan_io_line_a_out[i] <= ~chan_io_line_a_out[i];
        if (!wave[i])
          chan_io_line_b_out[i] <= 1'b0;
        else if (step[i] && cnt[i] == CNT_MAX)
          chan_io_line_b_out[i] <= ~chan_io_line_b_out[i];
      end
    end
  end

  // ==========================================
  // read port: data stands in the cycle after the strobe
  reg [`TCC_DATA_W-1:0] rmux;
  reg [1:0] rch;

  always @* begin
    rmux = {`TCC_DATA_W{1'b0}};
    rch = reg_addr[7:6];
    if (reg_addr == `TCC_ADDR_BMR) begin
      rmux[`TCC_BMR_W-1:0] = bmr;
    end else if (!is_block) begin
      case (off)
        `TCC_OFF_CMR: rmux[`TCC_CMR_W-1:0] = cmr[rch];
        `TCC_OFF_CV: rmux = {{PAD_W{1'b0}}, cnt[rch]};
        `TCC_OFF_RA: rmux = {{PAD_W{1'b0}}, cap_a[rch]};
        `TCC_OFF_RB: rmux = {{PAD_W{1'b0}}, cap_b[rch]};
        `TCC_OFF_RC: rmux = {{PAD_W{1'b0}}, per[rch]};
        `TCC_OFF_SR: begin
          rmux[`TCC_SR_OVF] = ovf[rch];
          rmux[`TCC_SR_OVR] = ovr[rch];
          rmux[`TCC_SR_CLKON] = clk_en[rch];
          rmux[`TCC_SR_LVLA] = line_a[rch];
          rmux[`TCC_SR_LVLB] = line_b[rch];
        end
        default: rmux = {`TCC_DATA_W{1'b0}};
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (srst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rmux;
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule // tcc_core

// *** design/tcc_regs.vh ***
// Purpose: register map, field positions and codes of the three channel timer
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes: definitions only
`ifndef TCC_REGS_VH
`define TCC_REGS_VH

// ==========================================
// address map
`define TCC_ADDR_W 8
`define TCC_DATA_W 32
`define TCC_OFF_CCR 6'h00
`define TCC_OFF_CMR 6'h04
`define TCC_OFF_CV 6'h10
`define TCC_OFF_RA 6'h14
`define TCC_OFF_RB 6'h18
`define TCC_OFF_RC 6'h1c
`define TCC_OFF_SR 6'h20
`define TCC_BLOCK_SEL 2'h3
`define TCC_ADDR_BCR 8'hc0
`define TCC_ADDR_BMR 8'hc4

// ==========================================
// channel command bits
`define TCC_CCR_EN 0
`define TCC_CCR_DIS 1
`define TCC_CCR_SOFT_TRIGGER_CMD 2
// block command bits
`define TCC_BCR_SYNC 0

// ==========================================
// channel mode fields
`define TCC_CMR_W 20
`define TCC_CMR_CLKSEL 2:0
`define TCC_CMR_CLKINV 3
`define TCC_CMR_GATE 5:4
`define TCC_CMR_STOP 6
`define TCC_CMR_DIS 7
`define TCC_CMR_TRGEDGE 9:8
`define TCC_CMR_EVSRC 11:10
`define TCC_CMR_CAPSRC_A 10
`define TCC_CMR_EVTRG_EN 12
`define TCC_CMR_CTRG 14
`define TCC_CMR_WAVE 15
`define TCC_CMR_LDA 17:16
`define TCC_CMR_LDB 19:18
`define TCC_CMR_RST 20'h0_0000

// clock source codes: 0..4 internal, 5..7 ext_clk_in 0..2
`define TCC_CLK_DIV2 3'h0
`define TCC_CLK_DIV8 3'h1
`define TCC_CLK_DIV32 3'h2
`define TCC_CLK_DIV128 3'h3
`define TCC_CLK_DIV1024 3'h4
`define TCC_CLK_XC0 3'h5
`define TCC_CLK_XC1 3'h6
`define TCC_CLK_XC2 3'h7

// prescaler bits whose level is master clock / 2, 8, 32, 128, 1024
`define TCC_PRE_W 10
`define TCC_PRE_ONE 10'h001
`define TCC_PRE_RST 10'h000
`define TCC_BIT_DIV2 0
`define TCC_BIT_DIV8 2
`define TCC_BIT_DIV32 4
`define TCC_BIT_DIV128 6
`define TCC_BIT_DIV1024 9

// edge codes
`define TCC_EDGE_NONE 2'h0
`define TCC_EDGE_RISE 2'h1
`define TCC_EDGE_FALL 2'h2
`define TCC_EDGE_BOTH 2'h3

// gate and event source codes
`define TCC_GATE_NONE 2'h0
`define TCC_EV_LINE_B 2'h0

// block mode: two bits per ext_clk_in
`define TCC_BMR_W 6
`define TCC_BMR_RST 6'h00
`define TCC_XC_PIN 2'h0
`define TCC_XC_OFF 2'h1
`define TCC_XC_NEXT 2'h2
`define TCC_XC_PREV 2'h3

// ==========================================
// status bits
`define TCC_SR_OVF 0
`define TCC_SR_OVR 1
`define TCC_SR_CLKON 16
`define TCC_SR_LVLA 17
`define TCC_SR_LVLB 18

`endif

// *** test/tcc_pin_model.sv ***
// Purpose: far-side pins of the timer: external clock sources
// Assumes: HALF_NS above one master period and period of 25 ns or more
// Notes: a source that is not running stands at 0
`timescale 1ns/100ps

// ==========================================
// pin model
module tcc_pin_model #(
  parameter HALF_NS = 30
) (
  // control
  input wire [2:0] run,
  // pins
  output reg [2:0] ext_clock_pin
);
  initial begin
    ext_clock_pin = 3'h0;
    forever begin
      // levels of 30 ns against a 10 ns master period
      #HALF_NS ext_clock_pin = run & ~ext_clock_pin;
    end
  end
endmodule // tcc_pin_model

// *** test/tcc_core_properties.sv ***
// Purpose: port-level properties of the three channel timer
// Assumes: channel stride 0x40 on the byte register port
// Notes: bound into every tcc_core
`timescale 1ns/100ps

// ==========================================
// checker
module tcc_core_properties #(
  parameter CNT_W = 16
) (
  // clock and reset
  input wire sys_clk,
  input wire srst,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // pins
  input wire [2:0] chan_io_line_a_out,
  input wire [2:0] chan_io_line_a_oe,
  input wire [2:0] chan_io_line_b_oe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  sequence s_dis0;
    reg_wr && reg_addr == 8'h00 && reg_wdata[1];
  endsequence
  sequence s_sr0;
    reg_rd && reg_addr == 8'h20;
  endsequence

  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  chk_reset_quiet: assert property ($fell(srst) |->
    reg_rdata == 32'h0000_0000 && chan_io_line_a_oe == 3'h0 && chan_io_line_b_oe == 3'h0)
    else $error("outputs busy after reset");
  chk_oe_a_wave: assert property ($past(reg_wr, 2) && $past(reg_addr, 2) == 8'h04
    && !$past(reg_wr) |-> chan_io_line_a_oe[0] == $past(reg_wdata[15], 2))
    else $error("line a enable not the mode bit");
  chk_oe_b_mode: assert property ((chan_io_line_b_oe & ~chan_io_line_a_oe) == 3'h0)
    else $error("line b driven in capture");
  chk_out_a_cap: assert property (chan_io_line_a_oe == 3'h0
    && $past(chan_io_line_a_oe) == 3'h0 |-> chan_io_line_a_out == 3'h0)
    else $error("line a out set in capture");
  chk_oe_cause: assert property ($changed(chan_io_line_a_oe) |->
    $past(reg_wr) || $past(reg_wr, 2))
    else $error("line a enable moved alone");
  chk_dis_flag: assert property (s_dis0 ##1 s_sr0 |=> !reg_rdata[16])
    else $error("enabled flag after disable");
  chk_sr_zero: assert property (reg_rd && reg_addr[5:0] == 6'h20
    && reg_addr[7:6] != 2'h3 |=> reg_rdata[15:2] == 14'h0 && reg_rdata[31:19] == 13'h0)
    else $error("status spare bits set");
  chk_cv_width: assert property (reg_rd && reg_addr[5:0] == 6'h10
    && reg_addr[7:6] != 2'h3 |=> (reg_rdata >> CNT_W) == 32'h0000_0000)
    else $error("counter wider than its width");
endmodule // tcc_core_properties

bind tcc_core tcc_core_properties #(.CNT_W(CNT_W)) tcc_core_properties_i (
  .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .chan_io_line_a_out(chan_io_line_a_out), .chan_io_line_a_oe(chan_io_line_a_oe),
  .chan_io_line_b_oe(chan_io_line_b_oe)
);

// *** test/tcc_core_test.sv ***
// Purpose: self-checking bench of the three channel timer
// Assumes: counter narrowed to 8 bits so a wrap fits the run
// Notes: line pins resolved from the drive enables
`timescale 1ns/100ps

// ==========================================
// bench top
module tcc_core_test;
  localparam CW = 8;
  reg sys_clk;
  reg srst;
  reg [7:0] reg_addr;
  reg [31:0] reg_wdata;
  reg reg_wr;
  reg reg_rd;
  reg [2:0] src_run;
  reg [2:0] a_drv;
  wire [31:0] reg_rdata;
  wire [2:0] ext_clock_pin;
  wire [2:0] a_out;
  wire [2:0] a_oe;
  wire [2:0] b_out;
  wire [2:0] b_oe;
  wire [2:0] a_pin;
  wire [2:0] b_pin;
  integer failures;
  integer samples_checked;
  integer i;
  integer ch;
  reg [31:0] q;
  reg [31:0] q2;
  reg [31:0] rc;

  assign a_pin = (a_oe & a_out) | (~a_oe & a_drv);
  assign b_pin = b_oe & b_out;

  tcc_core #(.CNT_W(CW)) tcc_core_i (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clock_pin(ext_clock_pin),
    .chan_io_line_a_in(a_pin), .chan_io_line_a_out(a_out), .chan_io_line_a_oe(a_oe),
    .chan_io_line_b_in(b_pin), .chan_io_line_b_out(b_out), .chan_io_line_b_oe(b_oe)
  );
  tcc_pin_model #(.HALF_NS(30)) tcc_pin_model_i (.run(src_run), .ext_clock_pin(ext_clock_pin));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ==========================================
  // tasks and expectations
  task acc(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      reg_wr <= w;
      reg_rd <= ~w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
    end
  endtask
  task wt(input integer c);
    repeat (c) @(posedge sys_clk);
  endtask
  // line a pulses of 4 master periods, well over one
  task pulse(input integer k);
    repeat (k) begin
      @(posedge sys_clk);
      a_drv[2] <= 1'b1;
      wt(4);
      a_drv[2] <= 1'b0;
      wt(16);
    end
  endtask
  task cmp_eq(input string nm, input [31:0] e, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("ERROR %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task cmp_rng(input string nm, input [31:0] lo, input [31:0] hi, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if ((g >= lo && g <= hi) !== 1'b1) begin
        failures = failures + 1;
        $display("ERROR %0s expected %0d..%0d seen %h", nm, lo, hi, g);
      end
    end
  endtask
  function [31:0] dv(input [2:0] c);
    dv = (c == 3'h0) ? 2 : (c == 3'h1) ? 8 : (c == 3'h2) ? 32 : (c == 3'h3) ? 128 : 1024;
  endfunction
  function [7:0] ca(input integer c, input [7:0] o);
    ca = {c[1:0], 6'h00} | o;
  endfunction
  task end_sim;
    begin
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  initial begin
    // tests take about 10k cycles; limit at twice that
    #200_000;
    failures = failures + 1;
    end_sim;
  end

  // ==========================================
  // main sequence
  initial begin
    failures = 0;
    samples_checked = 0;
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    src_run = 3'h0;
    a_drv = 3'h0;
    void'($urandom(32'h1f228594));
    wt(16);
    srst <= 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      acc(0, ca(i, 8'h04), 0);
      cmp_eq("cmr", 0, q);
      acc(0, ca(i, 8'h20), 0);
      cmp_eq("sr", 0, q);
      acc(0, ca(i, 8'h08), 0);
      cmp_eq("hole", 0, q);
    end
    acc(0, 8'hc4, 0);
    cmp_eq("bmr", 0, q);
    // every internal divider, soft and block triggers in turn
    for (i = 0; i < 5; i = i + 1) begin
      ch = $urandom % 3;
      acc(1, ca(ch, 8'h04), i);
      if (i[0]) begin
        acc(1, ca(ch, 8'h00), 32'h0000_0001);
        acc(1, 8'hc0, 32'h0000_0001);
      end else
        acc(1, ca(ch, 8'h00), 32'h0000_0005);
      wt(6 * dv(i[2:0]));
      acc(0, ca(ch, 8'h10), 0);
      cmp_rng("cv", 4, 6, q);
    end
    acc(1, 8'h04, 0);
    acc(1, 8'h00, 32'h0000_0005);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= 8'h00;
    reg_wdata <= 32'h0000_0002;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= 8'h20;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 cmp_eq("clk_on", 0, reg_rdata & 32'h0001_0000);
    acc(1, 8'h00, 32'h0000_0004);
    acc(1, 8'h00, 32'h0000_0001);
    acc(0, 8'h10, 0);
    q2 = q;
    wt(20);
    acc(0, 8'h10, 0);
    cmp_eq("frozen", q2, q);
    acc(0, 8'h20, 0);
    acc(1, 8'h00, 32'h0000_0005);
    wt(2 * (1 << CW) + 20);
    acc(0, 8'h20, 0);
    cmp_eq("ovf", 32'h0001_0001, q & 32'h0001_0003);
    acc(0, 8'h20, 0);
    cmp_eq("ovf_clr", 32'h0001_0000, q & 32'h0001_0003);
    // period match retriggers, so no wrap and the count stays at or below it
    rc = 3 + $urandom % 8;
    acc(1, ca(1, 8'h1c), rc);
    acc(1, ca(1, 8'h04), 32'h0000_4000);
    acc(1, ca(1, 8'h00), 32'h0000_0005);
    acc(0, ca(1, 8'h20), 0);
    for (i = 0; i < 4; i = i + 1) begin
      wt($urandom % 200 + 40);
      acc(0, ca(1, 8'h10), 0);
      cmp_rng("cv_rc", 0, rc, q);
    end
    wt(2 * (1 << CW));
    acc(0, ca(1, 8'h20), 0);
    cmp_eq("no_wrap", 0, q & 32'h0000_0001);
    // waveform mode: line b drive toggles once per wrap
    acc(1, ca(1, 8'h04), 32'h0000_8000);
    acc(1, ca(1, 8'h00), 32'h0000_0005);
    wt(2 * (1 << CW) + 20);
    #1 cmp_eq("b_wrap", 1, b_out[1]);
    acc(1, 8'h1c, 5);
    acc(1, 8'h04, 32'h0000_8040);
    acc(1, 8'h00, 32'h0000_0005);
    wt(40);
    acc(0, 8'h10, 0);
    cmp_eq("stop", 5, q);
    cmp_eq("oe", 32'h0000_0002, {30'h0, a_oe[0], b_oe[0]});
    acc(1, 8'h04, 32'h0000_8080);
    acc(1, 8'h00, 32'h0000_0005);
    wt(40);
    acc(0, 8'h20, 0);
    cmp_eq("dis", 0, q & 32'h0001_0000);
    // capture on line a rises, counting the external pin clock
    src_run <= 3'h1;
    acc(1, ca(2, 8'h04), 32'h0005_0005);
    acc(1, ca(2, 8'h00), 32'h0000_0005);
    // let the trigger land before the first capture edge
    wt(10);
    pulse(2);
    acc(0, ca(2, 8'h14), 0);
    q2 = q;
    acc(0, ca(2, 8'h18), 0);
    cmp_rng("rb_ra", 2, 5, q - q2);
    acc(0, ca(2, 8'h20), 0);
    cmp_eq("no_ovr", 0, q & 32'h0000_0002);
    pulse(3);
    acc(0, ca(2, 8'h20), 0);
    cmp_eq("ovr", 32'h0000_0002, q & 32'h0000_0002);
    acc(0, ca(2, 8'h14), 0);
    q2 = q;
    acc(0, ca(2, 8'h18), 0);
    cmp_rng("ra_rb", 2, 5, q2 - q);
    // line a rise as external trigger, inverted fastest clock
    acc(1, ca(2, 8'h04), 32'h0000_0508);
    pulse(1);
    acc(0, ca(2, 8'h10), 0);
    cmp_rng("ext_trg", 7, 10, q);
    end_sim;
  end
endmodule // tcc_core_test
